/* File: fcf_branch_model.sv */
// Behavioural integer execution and branch logic beside the compare block.
// Assumes the accumulator copy from the store status word op is its only input.
`timescale 1ns/1ps
module fcf_branch_model (
    accum,
    br_gt,
    br_lt,
    br_eq,
    br_un
);
    input  wire logic [15:0] accum;
    output logic             br_gt;
    output logic             br_lt;
    output logic             br_eq;
    output logic             br_un;

    // Branch decisions only on the accumulator copy, never on live bits
    always_comb begin
        br_gt = ((accum & fcf_pkg::MASK_GT) == 16'h0000);
        br_lt = ((accum & fcf_pkg::MASK_LT) != 16'h0000);
        br_eq = ((accum & fcf_pkg::MASK_EQ) != 16'h0000);
        br_un = ((accum & fcf_pkg::MASK_UN) != 16'h0000);
    end
endmodule

/* File: fcf_compare.sv */
// Compare and examine result logic: condition bits, integer flags, pop.
// Assumes operands arrive decoded as sign, exponent and significand,
// with a tag marking an empty stack-top register, valid for one cycle.
`timescale 1ns/1ps
module fcf_compare (
    ref_clk,
    rst_n,
    op_valid,
    op_code,
    a_sign,
    a_exp,
    a_mant,
    a_empty,
    b_sign,
    b_exp,
    b_mant,
    b_empty,
    status_word_r,
    accum_r,
    zero_flag_r,
    parity_flag_r,
    carry_flag_r,
    flags_valid_r,
    invalid_r,
    stack_pop_r,
    done_r,
    flag_cmp_supported_r
);
    input  wire logic        ref_clk;
    input  wire logic        rst_n;
    input  wire logic        op_valid;
    input  wire logic [2:0]  op_code;
    input  wire logic        a_sign;
    input  wire logic [14:0] a_exp;
    input  wire logic [63:0] a_mant;
    input  wire logic        a_empty;
    input  wire logic        b_sign;
    input  wire logic [14:0] b_exp;
    input  wire logic [63:0] b_mant;
    input  wire logic        b_empty;
    output logic      [15:0] status_word_r;
    output logic      [15:0] accum_r;
    output logic             zero_flag_r;
    output logic             parity_flag_r;
    output logic             carry_flag_r;
    output logic             flags_valid_r;
    output logic             invalid_r;
    output logic             stack_pop_r;
    output logic             done_r;
    output logic             flag_cmp_supported_r;

    logic [15:0] status_word_nxt;
    logic [15:0] accum_nxt;
    logic        zero_flag_nxt;
    logic        parity_flag_nxt;
    logic        carry_flag_nxt;
    logic        flags_valid_nxt;
    logic        invalid_nxt;
    logic        stack_pop_nxt;
    logic        done_nxt;
    logic        a_nan;
    logic        b_nan;
    logic        a_snan;
    logic        b_snan;
    logic        a_zero;
    logic        b_zero;
    logic        a_unsup;
    logic        b_unsup;
    logic        unord;
    logic        eq;
    logic        lt;
    logic        mag_lt;
    logic [2:0]  cmp_bits;
    logic [2:0]  cls_bits;

    // Operand classification helpers
    always_comb begin
        a_nan   = (a_exp == fcf_pkg::EXP_MAX) && a_mant[63] && (a_mant[62:0] != 63'h0);
        b_nan   = (b_exp == fcf_pkg::EXP_MAX) && b_mant[63] && (b_mant[62:0] != 63'h0);
        a_snan  = a_nan && !a_mant[62];
        b_snan  = b_nan && !b_mant[62];
        a_zero  = (a_exp == 15'h0) && (a_mant == 64'h0);
        b_zero  = (b_exp == 15'h0) && (b_mant == 64'h0);
        // Nonzero exponent without the explicit integer bit is unsupported
        a_unsup = (a_exp != 15'h0) && !a_mant[63];
        b_unsup = (b_exp != 15'h0) && !b_mant[63];
    end

    // Ordering of stack top against operand
    always_comb begin
        unord  = a_nan || b_nan || a_unsup || b_unsup || a_empty || b_empty;
        mag_lt = (a_exp < b_exp) || ((a_exp == b_exp) && (a_mant < b_mant));
        eq     = (a_zero && b_zero) ||
                 ((a_sign == b_sign) && (a_exp == b_exp) && (a_mant == b_mant));
        if (eq) begin
            lt = 1'b0;
        end else if (a_sign != b_sign) begin
            lt = a_sign;
        end else begin
            lt = a_sign ? !mag_lt : mag_lt;
        end
        // Bits three, two, zero; integer flags use the same pattern
        if (unord) begin
            cmp_bits = 3'h7;
        end else if (eq) begin
            cmp_bits = 3'h4;
        end else if (lt) begin
            cmp_bits = 3'h1;
        end else begin
            cmp_bits = 3'h0;
        end
    end

    // Examine class encoding, bits three, two, zero
    always_comb begin
        if (a_empty) begin
            cls_bits = 3'h5;
        end else if (a_unsup) begin
            cls_bits = 3'h0;
        end else if (a_nan) begin
            cls_bits = 3'h1;
        end else if ((a_exp == fcf_pkg::EXP_MAX) && (a_mant[62:0] == 63'h0)) begin
            cls_bits = 3'h3;
        end else if (a_zero) begin
            cls_bits = 3'h4;
        end else if (a_exp == 15'h0) begin
            cls_bits = 3'h6;
        end else begin
            cls_bits = 3'h2;
        end
    end

    // Next values for results
    always_comb begin
        status_word_nxt = status_word_r;
        accum_nxt       = accum_r;
        zero_flag_nxt   = zero_flag_r;
        parity_flag_nxt = parity_flag_r;
        carry_flag_nxt  = carry_flag_r;
        flags_valid_nxt = 1'b0;
        invalid_nxt     = 1'b0;
        stack_pop_nxt   = 1'b0;
        done_nxt        = op_valid && (op_code != fcf_pkg::OP_NONE);
        if (op_valid) begin
            case (op_code)
                fcf_pkg::OP_FCMP: begin
                    // Condition bits at word positions give the test masks
                    status_word_nxt[fcf_pkg::BIT_C3] = cmp_bits[2];
                    status_word_nxt[fcf_pkg::BIT_C2] = cmp_bits[1];
                    status_word_nxt[fcf_pkg::BIT_C0] = cmp_bits[0];
                    invalid_nxt = unord;
                end
                fcf_pkg::OP_FLAG, fcf_pkg::OP_FLAG_POP,
                fcf_pkg::OP_UFLAG, fcf_pkg::OP_UFLAG_POP: begin
                    zero_flag_nxt   = cmp_bits[2];
                    parity_flag_nxt = cmp_bits[1];
                    carry_flag_nxt  = cmp_bits[0];
                    flags_valid_nxt = 1'b1;
                    if ((op_code == fcf_pkg::OP_UFLAG) || (op_code == fcf_pkg::OP_UFLAG_POP)) begin
                        // Quiet NaNs stay silent; others still fault
                        invalid_nxt = unord && (a_snan || b_snan || a_unsup || b_unsup ||
                                                a_empty || b_empty);
                    end else begin
                        invalid_nxt = unord;
                    end
                    stack_pop_nxt = (op_code == fcf_pkg::OP_FLAG_POP) ||
                                    (op_code == fcf_pkg::OP_UFLAG_POP);
                end
                fcf_pkg::OP_EXAMINE: begin
                    status_word_nxt[fcf_pkg::BIT_C3] = cls_bits[2];
                    status_word_nxt[fcf_pkg::BIT_C2] = cls_bits[1];
                    status_word_nxt[fcf_pkg::BIT_C0] = cls_bits[0];
                    status_word_nxt[fcf_pkg::BIT_C1] = a_sign;
                end
                fcf_pkg::OP_STSW: begin
                    accum_nxt = status_word_r;
                end
                default: begin
                    done_nxt = 1'b0;
                end
            endcase
        end
    end

    // Result registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_word_r        <= fcf_pkg::STATUS_RST;
            accum_r              <= 16'h0000;
            zero_flag_r          <= 1'b0;
            parity_flag_r        <= 1'b0;
            carry_flag_r         <= 1'b0;
            flags_valid_r        <= 1'b0;
            invalid_r            <= 1'b0;
            stack_pop_r          <= 1'b0;
            done_r               <= 1'b0;
            flag_cmp_supported_r <= 1'b0;
        end else begin
            status_word_r        <= status_word_nxt;
            accum_r              <= accum_nxt;
            zero_flag_r          <= zero_flag_nxt;
            parity_flag_r        <= parity_flag_nxt;
            carry_flag_r         <= carry_flag_nxt;
            flags_valid_r        <= flags_valid_nxt;
            invalid_r            <= invalid_nxt;
            stack_pop_r          <= stack_pop_nxt;
            done_r               <= done_nxt;
            flag_cmp_supported_r <= fcf_pkg::FEATURE_PRESENT;
        end
    end

    // Checks
    sequence s_flag_op;
        op_valid && ((op_code == fcf_pkg::OP_FLAG) || (op_code == fcf_pkg::OP_FLAG_POP) ||
                     (op_code == fcf_pkg::OP_UFLAG) || (op_code == fcf_pkg::OP_UFLAG_POP));
    endsequence

    a_flag_unord: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_flag_op ##0 unord) |=> (zero_flag_r && parity_flag_r && carry_flag_r))
        else $error("unordered flag pattern wrong");
    a_flag_less: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_flag_op ##0 (!unord && lt && !eq)) |=>
        (!zero_flag_r && !parity_flag_r && carry_flag_r))
        else $error("less flag pattern wrong");
    a_flag_great: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_flag_op ##0 (!unord && !lt && !eq)) |=>
        !(zero_flag_r || parity_flag_r || carry_flag_r))
        else $error("greater flags not clear");
    a_feature_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) |-> flag_cmp_supported_r)
        else $error("feature bit missing");
    a_quiet_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && (op_code == fcf_pkg::OP_UFLAG || op_code == fcf_pkg::OP_UFLAG_POP) &&
         (a_nan || b_nan) && !a_snan && !b_snan && !a_unsup && !b_unsup &&
         !a_empty && !b_empty) |=> !invalid_r)
        else $error("quiet NaN raised invalid");
    a_pop_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stack_pop_r |=> !stack_pop_r || $past(op_valid))
        else $error("stack popped twice");
    a_pop_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stack_pop_r |-> $past(op_valid) && ($past(op_code) == fcf_pkg::OP_FLAG_POP ||
                                            $past(op_code) == fcf_pkg::OP_UFLAG_POP))
        else $error("pop without popping compare");
    a_exam_sign: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && op_code == fcf_pkg::OP_EXAMINE) |=>
        status_word_r[fcf_pkg::BIT_C1] == $past(a_sign))
        else $error("sign bit not set");
    a_exam_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && op_code == fcf_pkg::OP_EXAMINE && a_empty) |=>
        (status_word_r & fcf_pkg::MASK_GT) == 16'h4100)
        else $error("empty class wrong");
    a_mask_greater: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && op_code == fcf_pkg::OP_FCMP && !unord && !lt && !eq) |=>
        (status_word_r & fcf_pkg::MASK_GT) == 16'h0000)
        else $error("greater mask nonzero");
    a_mask_unord: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && op_code == fcf_pkg::OP_FCMP && unord) |=>
        (status_word_r & fcf_pkg::MASK_UN) != 16'h0000)
        else $error("unordered mask zero");
    a_store_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op_valid && op_code == fcf_pkg::OP_STSW) |=> accum_r == $past(status_word_r))
        else $error("accumulator not loaded");
endmodule

/* File: fcf_pkg.sv */
// Constants for the floating-point compare and classify result logic.
// Assumes the status word layout of a stack-based floating-point unit.
package fcf_pkg;
    // Operation codes presented on op_code
    localparam logic [2:0] OP_NONE      = 3'h0;
    localparam logic [2:0] OP_FCMP      = 3'h1; // ordinary_fp_compare
    localparam logic [2:0] OP_FLAG      = 3'h2; // flag_setting_compare
    localparam logic [2:0] OP_FLAG_POP  = 3'h3; // flag_setting_compare_pop
    localparam logic [2:0] OP_UFLAG     = 3'h4; // unordered_flag_compare
    localparam logic [2:0] OP_UFLAG_POP = 3'h5; // unordered_flag_compare_pop
    localparam logic [2:0] OP_EXAMINE   = 3'h6; // examine_class_op
    localparam logic [2:0] OP_STSW      = 3'h7; // store_status_word_op
    // Status word bit positions
    localparam int BIT_C0 = 8;
    localparam int BIT_C1 = 9;
    localparam int BIT_C2 = 10;
    localparam int BIT_C3 = 14;
    // Branch test masks
    localparam logic [15:0] MASK_GT = 16'h4500;
    localparam logic [15:0] MASK_LT = 16'h0100;
    localparam logic [15:0] MASK_EQ = 16'h4000;
    localparam logic [15:0] MASK_UN = 16'h0400;
    // Extended operand fields
    localparam int EXP_W  = 15;
    localparam int MANT_W = 64;
    localparam logic [14:0] EXP_MAX = 15'h7fff;
    // Reset value of the status word; feature bit value loaded after reset
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic        FEATURE_PRESENT = 1'b1;
endpackage

/* File: testbench.sv */
// Self-checking bench for the compare and examine result logic.
// Assumes one 40 MHz clock and results one cycle after each op.
`timescale 1ns/1ps
module testbench;
    // Operand layout: empty, sign, exponent, significand
    localparam logic [80:0] V_ONE  = {2'h0, 15'h3fff, 64'h8000000000000000};
    localparam logic [80:0] V_TWO  = {2'h0, 15'h4000, 64'h8000000000000000};
    localparam logic [80:0] V_PZ   = 81'h0;
    localparam logic [80:0] V_NZ   = {2'h1, 15'h0000, 64'h0};
    localparam logic [80:0] V_QNAN = {2'h0, 15'h7fff, 64'hc000000000000000};
    localparam logic [80:0] V_SNAN = {2'h0, 15'h7fff, 64'ha000000000000000};
    localparam logic [80:0] V_NINF = {2'h1, 15'h7fff, 64'h8000000000000000};
    localparam logic [80:0] V_DEN  = {2'h1, 15'h0000, 64'h1};
    localparam logic [80:0] V_UNS  = {2'h1, 15'h3fff, 64'h4000000000000000};
    localparam logic [80:0] V_EMP  = {2'h2, 15'h0000, 64'h0};
    // Cases: greater, less, equal zeros, unordered
    localparam logic [80:0] CA [4] = '{V_TWO, V_ONE, V_PZ, V_ONE};
    localparam logic [80:0] CB [4] = '{V_ONE, V_TWO, V_NZ, V_QNAN};
    localparam logic [2:0]  CC [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
    localparam logic [3:0]  CBR [4] = '{4'h8, 4'h4, 4'h2, 4'h7};
    localparam logic [80:0] EX [7] = '{V_UNS, V_QNAN, V_ONE, V_NINF, V_NZ, V_EMP, V_DEN};
    localparam logic [2:0]  EXC [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};

    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        op_valid = 1'h0;
    logic [2:0]  op_code = 3'h0;
    logic        a_sign = 1'h0, a_empty = 1'h0, b_sign = 1'h0, b_empty = 1'h0;
    logic [14:0] a_exp = 15'h0, b_exp = 15'h0;
    logic [63:0] a_mant = 64'h0, b_mant = 64'h0;
    logic [15:0] status_word_r, accum_r;
    logic        zero_flag_r, parity_flag_r, carry_flag_r, flags_valid_r;
    logic        invalid_r, stack_pop_r, done_r, flag_cmp_supported_r;
    logic        br_gt, br_lt, br_eq, br_un;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    fcf_compare i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .a_sign(a_sign), .a_exp(a_exp), .a_mant(a_mant),
        .a_empty(a_empty), .b_sign(b_sign), .b_exp(b_exp), .b_mant(b_mant),
        .b_empty(b_empty), .status_word_r(status_word_r), .accum_r(accum_r),
        .zero_flag_r(zero_flag_r), .parity_flag_r(parity_flag_r),
        .carry_flag_r(carry_flag_r), .flags_valid_r(flags_valid_r),
        .invalid_r(invalid_r), .stack_pop_r(stack_pop_r), .done_r(done_r),
        .flag_cmp_supported_r(flag_cmp_supported_r));

    fcf_branch_model i_branch (.accum(accum_r), .br_gt(br_gt), .br_lt(br_lt),
        .br_eq(br_eq), .br_un(br_un));

    // Clock and hang guard
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            end_sim();
        end
    end

    // Compare seen against expected
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Expected status word from condition bits three, two, zero and the sign bit
    function automatic logic [15:0] sw(input logic [2:0] cc, input logic c1);
        logic [15:0] w;
        w = 16'h0000;
        w[fcf_pkg::BIT_C3] = cc[2];
        w[fcf_pkg::BIT_C2] = cc[1];
        w[fcf_pkg::BIT_C1] = c1;
        w[fcf_pkg::BIT_C0] = cc[0];
        return w;
    endfunction

    // One op pulse, returns once its results have landed
    task automatic op(input logic [2:0] code, input logic [80:0] a, input logic [80:0] b);
        @(posedge ref_clk);
        op_valid <= 1'h1;
        op_code  <= code;
        {a_empty, a_sign, a_exp, a_mant} <= a;
        {b_empty, b_sign, b_exp, b_mant} <= b;
        @(posedge ref_clk);
        op_valid <= 1'h0;
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        @(posedge ref_clk);
        #1;
        chk("reset_feature", {15'h0, flag_cmp_supported_r}, 16'h0000);
        @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("feature", {15'h0, flag_cmp_supported_r}, 16'h0001);
        op(fcf_pkg::OP_NONE, V_ONE, V_ONE);
        chk("idle_done", {15'h0, done_r}, 16'h0000);
        $display("test reset done");
        // Ordinary compare, stored at once, branched on by the model
        for (int i = 0; i < 4; i++) begin
            op(fcf_pkg::OP_FCMP, CA[i], CB[i]);
            chk("fcmp_sw", status_word_r, sw(CC[i], 1'h0));
            chk("fcmp_inv", {15'h0, invalid_r}, {15'h0, i == 3});
            op(fcf_pkg::OP_STSW, V_ONE, V_ONE);
            chk("accum", accum_r, sw(CC[i], 1'h0));
            chk("branch", {12'h0, br_gt, br_lt, br_eq, br_un}, {12'h0, CBR[i]});
        end
        $display("test ordinary compare done");
        // All four flag-setting variants over all outcomes
        for (int c = 2; c < 6; c++) begin
            for (int i = 0; i < 4; i++) begin
                op(3'(c), CA[i], CB[i]);
                chk("flags", {13'h0, zero_flag_r, parity_flag_r, carry_flag_r},
                    {13'h0, CC[i]});
                chk("pulses", {13'h0, flags_valid_r, stack_pop_r, done_r},
                    {13'h0, 1'h1, c[0], 1'h1});
                chk("invalid", {15'h0, invalid_r}, {15'h0, i == 3 && c < 4});
                chk("sw_kept", status_word_r, 16'h4500);
            end
        end
        op(fcf_pkg::OP_UFLAG_POP, V_ONE, V_SNAN);
        chk("snan_inv", {14'h0, invalid_r, stack_pop_r}, 16'h0003);
        op(fcf_pkg::OP_UFLAG, V_EMP, V_ONE);
        chk("empty_inv", {15'h0, invalid_r}, 16'h0001);
        $display("test flag compare done");
        // Examine every class, with the sign of each operand
        for (int i = 0; i < 7; i++) begin
            op(fcf_pkg::OP_EXAMINE, EX[i], V_ONE);
            chk("exam_sw", status_word_r, sw(EXC[i], EX[i][79]));
            chk("exam_done", {15'h0, done_r}, 16'h0001);
        end
        $display("test examine done");
        end_sim();
    end
endmodule
